/* eic_core.sv */
// energy integration control: modes, commands, hold, overflow, lamps
// Summary of operation
// - mode setting normal or repeating, reset normal
// - normal with zero timer runs manual
// - normal with nonzero timer stops on expiry
// - timer range zero to 10000 hours
// - repeating with zero timer: error, no start
// - start lights start lamp, accumulates, shows
// - stop halts, start lamp off, stop on
// - reset restores values, lamp off, dashes
// - reset accepted only when stopped
// - hold freezes outputs, update pulses continue
// - hold release shows present values
// - single under hold refreshes then holds
// - stop keeps values of last update
// - value ceiling or floor stops integration
// - 10000 hours elapsed stops integration
// - overflow lights both lamps
// - time format steps by magnitude
// - time fits six-digit readout
// - value counts and prefix scaling
// - start under hold keeps held outputs
// - stop under hold presents stop results later
// - time readout has no element indication
// - repeating mode clears and restarts on expiry
// - power return: stopped, both lamps, reset needed
`default_nettype none
module eic_core #(
  parameter int unsigned TICK_CYCLES = eic_pkg::TICK_CYC
) (
  input  wire logic                    clock_in,
  input  wire logic                    srst_in,
  input  wire logic                    ce_in,
  input  wire logic                    power_restored_in,
  input  wire logic                    mode_in,
  input  wire logic [25:0]             timer_in,
  input  wire logic                    timer_wr_in,
  input  wire logic                    mode_wr_in,
  input  wire eic_pkg::eic_cmd_s       cmd_in,
  input  wire logic                    update_in,
  input  wire logic signed [31:0]      sample_in,
  input  wire logic                    element_key_in,
  output var  logic                    start_lamp_out,
  output var  logic                    stop_lamp_out,
  output var  logic                    update_led_out,
  output var  logic [3:0]              error_out,
  output var  logic                    integrating_out,
  output var  eic_pkg::eic_val_disp_s  value_out,
  output var  eic_pkg::eic_time_disp_s time_out,
  output var  logic                    element_shown_out,
  output var  logic signed [31:0]      comm_value_out,
  output var  logic [25:0]             comm_time_out
);
  typedef struct packed {
    eic_pkg::eic_state_e state;
    logic                mode;
    logic [25:0]         timer;
    logic [25:0]         tick_cnt;
    logic [25:0]         elapsed;
    logic signed [31:0]  acc;
    logic signed [31:0]  shown_acc;
    logic [25:0]         shown_time;
    logic signed [31:0]  out_acc;
    logic [25:0]         out_time;
    logic                held;
    logic                dashes;
    logic                start_lamp;
    logic                stop_lamp;
    logic                update_led;
    logic [3:0]          error;
    logic                element_shown;
  } eic_core_state_s;

  eic_core_state_s             st_q;
  eic_core_state_s             st_d;
  logic                        pwr_meta_q;
  logic                        pwr_sync_q;
  logic                        pwr_seen_q;
  logic                        tick;
  logic                        expire;
  logic signed [31:0]          acc_next;
  logic                        ovf;
  eic_pkg::eic_time_disp_s     fmt_disp;

  // power-return flag comes from outside the clock domain
  always_ff @(posedge clock_in) begin
    if (srst_in) begin
      pwr_meta_q <= 1'b0;
      pwr_sync_q <= 1'b0;
      pwr_seen_q <= 1'b0;
    end else if (ce_in) begin
      pwr_meta_q <= power_restored_in;
      pwr_sync_q <= pwr_meta_q;
      pwr_seen_q <= pwr_sync_q;
    end
  end

  assign tick = (st_q.state == eic_pkg::EIC_ST_RUN) && (st_q.tick_cnt == 26'(TICK_CYCLES - 1));
  assign expire = tick && (st_q.timer != 26'h0) && (26'(st_q.elapsed + 26'd1) == st_q.timer);
  assign acc_next = st_q.acc + sample_in;
  assign ovf = (acc_next >= eic_pkg::ACC_CEIL) || (acc_next <= eic_pkg::ACC_FLOOR);

  always_comb begin
    st_d = st_q;
    st_d.update_led = 1'b0;
    st_d.error = 4'h0;
    // element shown only off the time readout
    st_d.element_shown = 1'b0;
    if (st_q.state == eic_pkg::EIC_ST_RESET) begin
      if (mode_wr_in) begin
        st_d.mode = mode_in;
      end
      if (timer_wr_in) begin
        st_d.timer = (timer_in > eic_pkg::TIME_MAX_S) ? eic_pkg::TIME_MAX_S : timer_in;
      end
    end
    unique case (st_q.state)
      eic_pkg::EIC_ST_RESET: begin
        if (cmd_in.start) begin
          if (st_q.mode == eic_pkg::EIC_MODE_REPEAT && st_q.timer == 26'h0) begin
            st_d.error = eic_pkg::ERR_CODE;
          end else begin
            st_d.state = eic_pkg::EIC_ST_RUN;
            st_d.start_lamp = 1'b1;
            st_d.stop_lamp = 1'b0;
            st_d.tick_cnt = 26'h0;
            st_d.dashes = 1'b0;
          end
        end
      end
      eic_pkg::EIC_ST_RUN: begin
        st_d.tick_cnt = tick ? 26'h0 : 26'(st_q.tick_cnt + 26'd1);
        if (tick) begin
          st_d.elapsed = 26'(st_q.elapsed + 26'd1);
        end
        if (update_in) begin
          // update indicator pulses even when held
          st_d.update_led = 1'b1;
          st_d.acc = ovf ? ((acc_next >= eic_pkg::ACC_CEIL) ? eic_pkg::ACC_CEIL : eic_pkg::ACC_FLOOR) : acc_next;
          st_d.shown_acc = st_d.acc;
          st_d.shown_time = st_d.elapsed;
        end
        if (cmd_in.stop) begin
          // stop, roll back to last update
          st_d.state = eic_pkg::EIC_ST_STOP;
          st_d.start_lamp = 1'b0;
          st_d.stop_lamp = 1'b1;
          st_d.acc = st_q.shown_acc;
          st_d.elapsed = st_q.shown_time;
        end else if ((update_in && ovf) || (tick && 26'(st_q.elapsed + 26'd1) >= eic_pkg::TIME_MAX_S)) begin
          // overflow or time limit; both lamps on
          st_d.state = eic_pkg::EIC_ST_STOP;
          st_d.start_lamp = 1'b1;
          st_d.stop_lamp = 1'b1;
          st_d.shown_time = st_d.elapsed;
          st_d.shown_acc = st_d.acc;
        end else if (expire) begin
          if (st_q.mode == eic_pkg::EIC_MODE_REPEAT) begin
            st_d.acc = 32'sh0;
            st_d.elapsed = 26'h0;
            st_d.shown_acc = 32'sh0;
            st_d.shown_time = 26'h0;
          end else begin
            st_d.state = eic_pkg::EIC_ST_STOP;
            st_d.start_lamp = 1'b0;
            st_d.stop_lamp = 1'b1;
            st_d.shown_time = st_d.elapsed;
          end
        end
      end
      eic_pkg::EIC_ST_STOP: begin
        if (cmd_in.reset) begin
          // reset to pre-start values; only here
          st_d.state = eic_pkg::EIC_ST_RESET;
          st_d.acc = 32'sh0;
          st_d.elapsed = 26'h0;
          st_d.shown_acc = 32'sh0;
          st_d.shown_time = 26'h0;
          st_d.start_lamp = 1'b0;
          st_d.stop_lamp = 1'b0;
          st_d.dashes = 1'b1;
        end else if (cmd_in.start && !(st_q.start_lamp && st_q.stop_lamp)) begin
          // after overflow or power return a reset is needed
          st_d.state = eic_pkg::EIC_ST_RUN;
          st_d.start_lamp = 1'b1;
          st_d.stop_lamp = 1'b0;
          st_d.tick_cnt = 26'h0;
        end
      end
      default: begin
        st_d.state = eic_pkg::EIC_ST_RESET;
      end
    endcase
    // power return forces stopped with both lamps
    if (pwr_sync_q && !pwr_seen_q) begin
      st_d.state = eic_pkg::EIC_ST_STOP;
      st_d.start_lamp = 1'b1;
      st_d.stop_lamp = 1'b1;
    end
    if (cmd_in.hold) begin
      st_d.held = !st_q.held;
    end
    if (!st_q.held || cmd_in.hold || cmd_in.single) begin
      st_d.out_acc = st_d.shown_acc;
      st_d.out_time = st_d.shown_time;
    end
  end

  always_ff @(posedge clock_in) begin
    if (srst_in) begin
      st_q <= '0;
      st_q.state <= eic_pkg::EIC_ST_RESET;
      st_q.mode <= eic_pkg::MODE_RST;
      st_q.timer <= eic_pkg::TIMER_RST;
      st_q.dashes <= 1'b1;
    end else if (ce_in) begin
      st_q <= st_d;
    end
  end

  // time fields for the six-digit readout
  eic_time_fmt u_fmt (
    .clock_in   (clock_in),
    .srst_in    (srst_in),
    .ce_in      (ce_in),
    .seconds_in (st_q.out_time),
    .disp_out   (fmt_disp)
  );

  logic [1:0] prefix_q;
  logic       dash_q;
  logic       elem_unused;
  assign elem_unused = element_key_in;

  // prefix grows with magnitude: 0 milli, 1 unit, 2 kilo, 3 mega
  always_ff @(posedge clock_in) begin
    if (srst_in) begin
      prefix_q <= 2'h0;
      dash_q <= 1'b1;
    end else if (ce_in) begin
      dash_q <= st_q.dashes;
      if (st_q.out_acc > 32'sd99999 || st_q.out_acc < -32'sd99999) begin
        prefix_q <= 2'h3;
      end else if (st_q.out_acc > 32'sd9999 || st_q.out_acc < -32'sd9999) begin
        prefix_q <= 2'h2;
      end else if (st_q.out_acc > 32'sd999 || st_q.out_acc < -32'sd999) begin
        prefix_q <= 2'h1;
      end else begin
        prefix_q <= 2'h0;
      end
    end
  end

  always_comb begin
    time_out = fmt_disp;
    time_out.dashes = dash_q;
  end

  assign start_lamp_out    = st_q.start_lamp;
  assign stop_lamp_out     = st_q.stop_lamp;
  assign update_led_out    = st_q.update_led;
  assign error_out         = st_q.error;
  assign integrating_out   = (st_q.state == eic_pkg::EIC_ST_RUN);
  assign element_shown_out = st_q.element_shown;
  assign comm_value_out    = st_q.out_acc;
  assign comm_time_out     = st_q.out_time;
  assign value_out         = '{value: st_q.out_acc, prefix: prefix_q, dashes: dash_q};

  default clocking cb @(posedge clock_in); endclocking
  default disable iff (srst_in);

  sequence s_stop_req;
    ce_in && integrating_out && cmd_in.stop;
  endsequence

  a_stop_lamps: assert property (s_stop_req |=> stop_lamp_out && !start_lamp_out)
    else $error("stop did not switch lamps");
  a_reset_ignored: assert property (ce_in && integrating_out && cmd_in.reset |=> integrating_out || stop_lamp_out)
    else $error("reset accepted while integrating");
  a_repeat_error: assert property (ce_in && !integrating_out && !stop_lamp_out && cmd_in.start
      && st_q.mode && st_q.timer == 26'h0 |=> error_out == eic_pkg::ERR_CODE && !integrating_out)
    else $error("repeating start with zero timer not refused");
  a_start_lamp: assert property (ce_in && st_q.state == eic_pkg::EIC_ST_RESET && cmd_in.start && !st_q.mode
      && !(pwr_sync_q && !pwr_seen_q) |=> start_lamp_out && integrating_out)
    else $error("start lamp not lit");
  a_held_frozen: assert property (ce_in && st_q.held && !cmd_in.hold && !cmd_in.single
      |=> $stable(comm_value_out))
    else $error("held output changed");
  a_reset_dash: assert property (ce_in && st_q.state == eic_pkg::EIC_ST_STOP && cmd_in.reset
      && !(pwr_sync_q && !pwr_seen_q) |=> !stop_lamp_out ##1 ce_in [*1] ##0 value_out.dashes)
    else $error("reset did not dash readouts");
  a_tick_only_run: assert property (ce_in && !integrating_out |=> $stable(st_q.elapsed) || st_q.elapsed == 26'h0)
    else $error("elapsed moved while not running");
  a_ovf_lamps: assert property (ce_in && integrating_out && update_in && ovf && !cmd_in.stop
      |=> start_lamp_out && stop_lamp_out && !integrating_out)
    else $error("overflow lamps wrong");
endmodule
`default_nettype wire

/* eic_panel.sv */
// front-panel key model: key presses become one-cycle command pulses
`default_nettype none
module eic_panel (
  input  wire logic              clock_in,
  output var  eic_pkg::eic_cmd_s cmd_out
);
  timeunit 1ns;
  timeprecision 100ps;
  initial cmd_out = '0;
  // k: 0 start, 1 stop, 2 reset, 3 hold, 4 single; one clock per press
  task automatic press(input int k);
    @(posedge clock_in);
    #1;
    cmd_out = eic_pkg::eic_cmd_s'(5'h10 >> k);
    @(posedge clock_in);
    #1;
    cmd_out = '0;
  endtask
endmodule
`default_nettype wire

/* eic_pkg.sv */
// package for the energy integration control block
`default_nettype none
package eic_pkg;
  localparam int unsigned CLK_HZ        = 50_000_000;
  localparam int unsigned TICK_NS       = 1_000_000_000;
  localparam int unsigned TICK_CYC      = TICK_NS / (1_000_000_000 / CLK_HZ);
  localparam int unsigned TIME_W        = 26;
  localparam logic [25:0] TIME_MAX_S    = 26'(10000 * 3600);
  localparam logic [25:0] TIMER_RST     = 26'h0;
  localparam int unsigned ACC_W         = 32;
  localparam logic signed [31:0] ACC_CEIL  = 32'sd999999;
  localparam logic signed [31:0] ACC_FLOOR = -32'sd99999;
  localparam logic [3:0]  ERR_CODE      = 4'h1;
  localparam logic        MODE_RST      = 1'b0;

  typedef enum logic [0:0] {
    EIC_MODE_NORMAL = 1'b0,
    EIC_MODE_REPEAT = 1'b1
  } eic_mode_e;

  typedef enum logic [2:0] {
    EIC_ST_RESET = 3'b001,
    EIC_ST_RUN   = 3'b010,
    EIC_ST_STOP  = 3'b100
  } eic_state_e;

  typedef enum logic [1:0] {
    EIC_FMT_HMS = 2'h0,
    EIC_FMT_HM  = 2'h1,
    EIC_FMT_H   = 2'h2
  } eic_fmt_e;

  // formatted upper readout
  typedef struct packed {
    eic_fmt_e    fmt;
    logic [13:0] hours;
    logic [5:0]  minutes;
    logic [5:0]  seconds;
    logic        dashes;
  } eic_time_disp_s;

  // lower readout
  typedef struct packed {
    logic signed [31:0] value;
    logic [1:0]         prefix;
    logic               dashes;
  } eic_val_disp_s;

  typedef struct packed {
    logic start;
    logic stop;
    logic reset;
    logic hold;
    logic single;
  } eic_cmd_s;
endpackage
`default_nettype wire

/* eic_time_fmt.sv */
// elapsed seconds to six-digit readout fields
`default_nettype none
module eic_time_fmt (
  input  wire logic                    clock_in,
  input  wire logic                    srst_in,
  input  wire logic                    ce_in,
  input  wire logic [25:0]             seconds_in,
  output var  eic_pkg::eic_time_disp_s disp_out
);
  typedef struct packed {
    eic_pkg::eic_time_disp_s disp;
  } eic_fmt_state_s;

  eic_fmt_state_s st_q;
  eic_fmt_state_s st_d;
  logic [25:0]    mins;

  always_comb begin
    st_d = st_q;
    mins = seconds_in / 26'd60;
    st_d.disp.dashes  = 1'b0;
    st_d.disp.hours   = 14'(seconds_in / 26'd3600);
    st_d.disp.minutes = 6'(mins % 26'd60);
    st_d.disp.seconds = 6'(seconds_in % 26'd60);
    if (seconds_in >= eic_pkg::TIME_MAX_S) begin
      st_d.disp.fmt = eic_pkg::EIC_FMT_H;
    end else if (seconds_in >= 26'd360000) begin
      st_d.disp.fmt = eic_pkg::EIC_FMT_HM;
    end else begin
      st_d.disp.fmt = eic_pkg::EIC_FMT_HMS;
    end
  end

  always_ff @(posedge clock_in) begin
    if (srst_in) begin
      st_q <= '0;
    end else if (ce_in) begin
      st_q <= st_d;
    end
  end

  assign disp_out = st_q.disp;
endmodule
`default_nettype wire

/* energy_integration_control_tb.sv */
// self-checking bench for the energy integration control block
`default_nettype none
module energy_integration_control_tb;
  timeunit 1ns;
  timeprecision 100ps;
  logic clk, srst, pwr, mode, twr, mwr, upd_v, ekey;
  logic ce = 1'b1;
  logic [25:0] timer;
  logic signed [31:0] smp;
  eic_pkg::eic_cmd_s cmd;
  logic start_l, stop_l, led, integ, eshown;
  logic [3:0] errc;
  eic_pkg::eic_val_disp_s vdisp;
  eic_pkg::eic_time_disp_s tdisp;
  logic signed [31:0] cval;
  logic [25:0] ctime;
  int err_total, n_compared, model, led_cnt, err_cnt, cyc, base;
  int ovf[2] = '{999999, -99999};

  eic_panel u_panel (.clock_in(clk), .cmd_out(cmd));
  eic_core #(.TICK_CYCLES(4)) u_dut (
    .clock_in(clk), .srst_in(srst), .ce_in(ce), .power_restored_in(pwr),
    .mode_in(mode), .timer_in(timer), .timer_wr_in(twr), .mode_wr_in(mwr),
    .cmd_in(cmd), .update_in(upd_v), .sample_in(smp), .element_key_in(ekey),
    .start_lamp_out(start_l), .stop_lamp_out(stop_l), .update_led_out(led),
    .error_out(errc), .integrating_out(integ), .value_out(vdisp), .time_out(tdisp),
    .element_shown_out(eshown), .comm_value_out(cval), .comm_time_out(ctime));

  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  always @(posedge clk) begin
    if (led === 1'b1) led_cnt++;
    if (errc === eic_pkg::ERR_CODE) err_cnt++;
  end

  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      err_total++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic upd(input int v);
    upd_v = 1'b1;
    smp = v;
    ekey = $urandom_range(1);
    tick(1);
    upd_v = 1'b0;
    model += v;
    tick(2);
  endtask
  task automatic key(input int k, input int w);
    u_panel.press(k);
    tick(w);
  endtask
  task automatic cfg(input logic m, input logic [25:0] t);
    mode = m;
    timer = t;
    mwr = 1'b1;
    twr = 1'b1;
    tick(1);
    mwr = 1'b0;
    twr = 1'b0;
  endtask
  task automatic lamps(input logic s, input logic p, input logic i);
    chk(start_l, s);
    chk(stop_l, p);
    chk(integ, i);
  endtask
  task automatic final_report;
    $display("compared %0d mismatches %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  initial begin
    #100us;
    err_total++;
    final_report;
  end

  initial begin
    void'($urandom(32'hae7e));
    {srst, pwr, mode, twr, mwr, upd_v, ekey} = 7'h40;
    timer = '0;
    smp = '0;
    tick(3);
    srst = 1'b0;
    tick(2);
    lamps(0, 0, 0);
    chk(vdisp.dashes, 1);
    // manual run, refused reset, stop, reset
    key(0, 1);
    lamps(1, 0, 1);
    repeat (4) upd($urandom_range(500));
    chk(cval, model);
    // a stop key while the clock enable is low must leave the run untouched
    ce = 1'b0;
    key(1, 1);
    ce = 1'b1;
    chk(integ, 1);
    chk(start_l, 1);
    key(2, 1);
    chk(integ, 1);
    key(1, 1);
    lamps(0, 1, 0);
    chk(cval, model);
    key(2, 2);
    model = 0;
    lamps(0, 0, 0);
    chk({vdisp.dashes, tdisp.dashes}, 2'b11);
    // hold while running, single, release
    key(0, 1);
    upd(7);
    base = model;
    key(3, 1);
    led_cnt = 0;
    repeat (3) upd($urandom_range(300));
    chk(cval, base);
    chk(led_cnt, 3);
    key(4, 2);
    chk(cval, model);
    base = model;
    upd(9);
    chk(cval, base);
    key(3, 2);
    chk(cval, model);
    key(1, 1);
    key(2, 2);
    model = 0;
    // start and stop under hold
    key(3, 1);
    key(0, 1);
    upd(40);
    upd(2);
    chk(cval, 0);
    key(1, 1);
    key(3, 2);
    chk(cval, model);
    key(2, 2);
    model = 0;
    // overflow at ceiling and floor, then refused start
    foreach (ovf[i]) begin
      key(0, 1);
      upd(ovf[i]);
      lamps(1, 1, 0);
      chk(cval, ovf[i]);
      chk(vdisp.prefix, (i == 0) ? 3 : 2);
      key(0, 1);
      chk(integ, 0);
      key(2, 2);
      model = 0;
    end
    // standard run ends on timer expiry
    cfg(1'b0, 26'h3);
    key(0, 1);
    cyc = 0;
    while (integ === 1'b1 && cyc < 100) begin
      tick(1);
      cyc++;
    end
    chk(cyc >= 10 && cyc <= 14, 1);
    lamps(0, 1, 0);
    chk(ctime, 3);
    tick(2);
    chk(tdisp.seconds, 3);
    chk(tdisp.fmt, eic_pkg::EIC_FMT_HMS);
    chk(tdisp.hours, 0);
    key(2, 2);
    // repeating with zero timer is refused
    cfg(1'b1, 26'h0);
    err_cnt = 0;
    key(0, 2);
    chk(err_cnt, 1);
    chk(integ, 0);
    // repeating keeps running past expiry
    cfg(1'b1, 26'h2);
    key(0, 30);
    chk(integ, 1);
    key(1, 1);
    key(2, 2);
    cfg(1'b0, 26'h0);
    // power return during a run
    key(0, 1);
    pwr = 1'b1;
    tick(5);
    lamps(1, 1, 0);
    key(0, 1);
    chk(integ, 0);
    chk(eshown, 0);
    key(2, 2);
    lamps(0, 0, 0);
    final_report;
  end
endmodule
`default_nettype wire
